// *** rtl/freq_meter_consts.svh ***
// Purpose: Offsets, field positions and reset values of the frequency meter
// Assumes: Byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef FREQ_METER_CONSTS_SVH
`define FREQ_METER_CONSTS_SVH

`define ADDR_W 10
`define OFF_CTRL 10'h000
`define OFF_MODE 10'h004
`define OFF_STATUS 10'h008
`define OFF_VALUE 10'h00C
`define OFF_IER 10'h010
`define OFF_IDR 10'h014
`define OFF_IMR 10'h018
`define OFF_ISR 10'h01C
`define OFF_ICR 10'h020
`define OFF_VERSION 10'h3FC

`define START_BIT 0
`define REF_CLOCK_ENABLE_BIT 31
`define MEASURED_CLOCK_SELECT_MSB 20
`define MEASURED_CLOCK_SELECT_LSB 16
`define REF_CYCLE_COUNT_MSB 15
`define REF_CYCLE_COUNT_LSB 8
`define REF_CLOCK_SELECT_MSB 2
`define REF_CLOCK_SELECT_LSB 0
`define MODE_MASK 32'h801F_FF07
`define MODE_RESET 32'h0000_0000

`define STAT_BUSY_BIT 0
`define STAT_RPEND_BIT 1
`define IRQ_DONE_BIT 0
`define IRQ_RDY_BIT 1
`define IRQ_W 2

`define VALUE_W 24
`define REF_CYCLE_COUNT_W 8
`define SEL_W 5

`endif

// *** rtl/freq_meter_pkg.sv ***
// Purpose: Types shared by the frequency meter modules
// Assumes: Nothing
// Notes: Constants live in freq_meter_consts.svh
`default_nettype none

package freq_meter_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_ARM = 3'h2,
      ST_RUN = 3'h4
   } eng_state_e;
endpackage : freq_meter_pkg

`default_nettype wire

// *** rtl/meas_if.sv ***
// Purpose: Link between register front end and measurement engine
// Assumes: Single clock domain
// Notes: Edges are one-cycle pulses of synchronised clocks
`include "freq_meter_consts.svh"
`default_nettype none

interface meas_if;
   logic start;
   logic meas_edge;
   logic ref_edge;
   logic [`REF_CYCLE_COUNT_W-1:0] ref_num;
   logic busy;
   logic [`VALUE_W-1:0] result;
   modport ctrl (output start, meas_edge, ref_edge, ref_num, input busy, result);
   modport engine (input start, meas_edge, ref_edge, ref_num, output busy, result);
endinterface : meas_if

`default_nettype wire

// *** rtl/meas_engine.sv ***
// Purpose: Counts measured-clock edges over a number of reference edges
// Assumes: Edge pulses already synchronised to clock_i
// Notes: Count saturates at full scale
`include "freq_meter_consts.svh"
`default_nettype none

module meas_engine (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // Control link
   meas_if.engine m
);
   freq_meter_pkg::eng_state_e state_r;
   logic [`VALUE_W-1:0] cnt_r;
   logic [`VALUE_W-1:0] cnt_nxt;
   logic [`VALUE_W-1:0] result_r;
   logic [`REF_CYCLE_COUNT_W-1:0] ref_cnt_r;
   logic [`REF_CYCLE_COUNT_W-1:0] ref_cnt_nxt;
   logic last;

   // Zero programmed length wraps to full 256 cycles
   assign ref_cnt_nxt = ref_cnt_r + `REF_CYCLE_COUNT_W'(1);
   assign last = m.ref_edge && (ref_cnt_nxt == m.ref_num);
   assign cnt_nxt = (m.meas_edge && (cnt_r != '1)) ? cnt_r + `VALUE_W'(1) : cnt_r;
   assign m.busy = (state_r != freq_meter_pkg::ST_IDLE);
   assign m.result = result_r;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_r <= freq_meter_pkg::ST_IDLE;
      end else begin
         case (state_r)
            freq_meter_pkg::ST_IDLE: if (m.start) state_r <= freq_meter_pkg::ST_ARM;
            freq_meter_pkg::ST_ARM: if (!m.start && m.ref_edge) state_r <= freq_meter_pkg::ST_RUN;
            freq_meter_pkg::ST_RUN: begin
               if (m.start) state_r <= freq_meter_pkg::ST_ARM;
               else if (last) state_r <= freq_meter_pkg::ST_IDLE;
            end
            default: state_r <= freq_meter_pkg::ST_IDLE;
         endcase
      end
   end

   // Window opens on a reference edge so both counts align
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_r <= '0;
         ref_cnt_r <= '0;
      end else if (m.start || state_r != freq_meter_pkg::ST_RUN) begin
         cnt_r <= '0;
         ref_cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
         if (m.ref_edge) ref_cnt_r <= ref_cnt_nxt;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         result_r <= '0;
      end else if (state_r == freq_meter_pkg::ST_RUN && last && !m.start) begin
         result_r <= cnt_nxt;
      end
   end

   run_end_a : assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      (state_r == freq_meter_pkg::ST_RUN && last && !m.start) |=> !m.busy)
      else $error("engine did not stop at programmed length");
   result_hold_a : assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      (m.busy && !(state_r == freq_meter_pkg::ST_RUN && last && !m.start))
         |=> $stable(result_r))
      else $error("result changed while busy");
endmodule : meas_engine

`default_nettype wire

// *** rtl/freq_meter.sv ***
// Purpose: Register front end and clock selection of the frequency meter
// Assumes: Source clocks slower than half of clock_i
// Notes: Reads answer one cycle later; irq_o lags pending bits by one cycle
`include "freq_meter_consts.svh"
`default_nettype none

// Summary of operation
// - Writing start bit one launches measurement
// - Mode top bit enables reference clock
// - Mode bits 20..16 select measured clock
// - Mode bits 15..8 give reference cycles
// - Mode bits 2..0 select reference clock
// - Pending flag high until reference clock ready
// - Busy flag high during measurement
// - Result in bits 23..0, upper zero
// - Enable-set register sets mask bits
// - Enable-clear register clears mask bits
// - Mask view shows enabled sources
// - Pending bits set on status falling edge
// - Pending-clear register clears pending bits
// - Identification word holds version and variant
// - Result counts measured cycles over window
// - Interrupt is OR of masked pending
// - Mode write sets pending until applied
module freq_meter #(
   parameter int MEAS_SRCS = 32,
   parameter int REF_SRCS = 8,
   parameter logic [11:0] VERSION_NUM = 12'h123, // Value is arbitrary
   parameter logic [3:0] VARIANT_NUM = 4'h0 // Value is arbitrary
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // Register port
   input wire logic [`ADDR_W-1:0] addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   output logic [31:0] rd_data_o,
   // Candidate clocks
   input wire logic [MEAS_SRCS-1:0] meas_src_i,
   input wire logic [REF_SRCS-1:0] ref_src_i,
   // Interrupt
   output logic irq_o
);
   generate
      if (MEAS_SRCS < 1 || MEAS_SRCS > 32 || REF_SRCS < 1 || REF_SRCS > 8) begin : g_chk
         $error("source counts out of range");
      end
   endgenerate

   meas_if m ();

   logic [31:0] mode_r;
   logic [`IRQ_W-1:0] mask_r;
   logic [`IRQ_W-1:0] pend_r;
   logic [`IRQ_W-1:0] pend_nxt;
   logic [`IRQ_W-1:0] ev;
   logic ref_pend_r;
   logic ref_pend_d_r;
   logic ref_gate_r;
   logic busy_d_r;
   logic irq_r;
   logic [31:0] rd_data_r;
   logic [31:0] rd_val;
   logic wr_ctrl;
   logic wr_mode;
   logic wr_ier;
   logic wr_idr;
   logic wr_icr;
   logic ref_raw_edge;
   logic [MEAS_SRCS-1:0] meas_s1_r;
   logic [MEAS_SRCS-1:0] meas_s2_r;
   logic [MEAS_SRCS-1:0] meas_s3_r;
   logic [REF_SRCS-1:0] ref_s1_r;
   logic [REF_SRCS-1:0] ref_s2_r;
   logic [REF_SRCS-1:0] ref_s3_r;

   function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   // Rising edge of one source out of a padded vector
   function automatic logic pick_edge(input logic [31:0] now, input logic [31:0] old,
                                      input logic [`SEL_W-1:0] idx);
      pick_edge = now[idx] && !old[idx];
   endfunction : pick_edge

   assign wr_ctrl = wr_en_i && hit(addr_i, `OFF_CTRL);
   assign wr_mode = wr_en_i && hit(addr_i, `OFF_MODE);
   assign wr_ier = wr_en_i && hit(addr_i, `OFF_IER);
   assign wr_idr = wr_en_i && hit(addr_i, `OFF_IDR);
   assign wr_icr = wr_en_i && hit(addr_i, `OFF_ICR);

   // Two-stage synchronisers, third stage only for edge detection
   genvar gi;
   generate
      for (gi = 0; gi < MEAS_SRCS; gi++) begin : g_meas_sync
         always_ff @(posedge clock_i or negedge rstn_i) begin
            if (!rstn_i) begin
               meas_s1_r[gi] <= 1'b0;
               meas_s2_r[gi] <= 1'b0;
               meas_s3_r[gi] <= 1'b0;
            end else begin
               meas_s1_r[gi] <= meas_src_i[gi];
               meas_s2_r[gi] <= meas_s1_r[gi];
               meas_s3_r[gi] <= meas_s2_r[gi];
            end
         end
      end
      for (gi = 0; gi < REF_SRCS; gi++) begin : g_ref_sync
         always_ff @(posedge clock_i or negedge rstn_i) begin
            if (!rstn_i) begin
               ref_s1_r[gi] <= 1'b0;
               ref_s2_r[gi] <= 1'b0;
               ref_s3_r[gi] <= 1'b0;
            end else begin
               ref_s1_r[gi] <= ref_src_i[gi];
               ref_s2_r[gi] <= ref_s1_r[gi];
               ref_s3_r[gi] <= ref_s2_r[gi];
            end
         end
      end
   endgenerate

   // Reserved selections land on zero-padded bits and never tick
   assign m.meas_edge = pick_edge(32'(meas_s2_r), 32'(meas_s3_r),
                                  mode_r[`MEASURED_CLOCK_SELECT_MSB:`MEASURED_CLOCK_SELECT_LSB]);
   assign ref_raw_edge = pick_edge(32'(ref_s2_r), 32'(ref_s3_r),
                                   `SEL_W'(mode_r[`REF_CLOCK_SELECT_MSB:`REF_CLOCK_SELECT_LSB]));
   assign m.ref_edge = ref_raw_edge && ref_gate_r;
   assign m.ref_num = mode_r[`REF_CYCLE_COUNT_MSB:`REF_CYCLE_COUNT_LSB];
   assign m.start = wr_ctrl && wr_data_i[`START_BIT];

   meas_engine u_engine (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .m(m.engine)
   );

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_r <= `MODE_RESET;
      end else if (wr_mode) begin
         mode_r <= wr_data_i & `MODE_MASK;
      end
   end

   // Gate changes only on an edge of the selected source; a dead source keeps pending
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ref_pend_r <= 1'b0;
         ref_gate_r <= 1'b0;
      end else if (wr_mode) begin
         ref_pend_r <= 1'b1;
      end else if (ref_pend_r && ref_raw_edge) begin
         ref_pend_r <= 1'b0;
         ref_gate_r <= mode_r[`REF_CLOCK_ENABLE_BIT];
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mask_r <= '0;
      end else if (wr_ier) begin
         mask_r <= mask_r | wr_data_i[`IRQ_W-1:0];
      end else if (wr_idr) begin
         mask_r <= mask_r & ~wr_data_i[`IRQ_W-1:0];
      end
   end

   assign ev[`IRQ_DONE_BIT] = busy_d_r && !m.busy;
   assign ev[`IRQ_RDY_BIT] = ref_pend_d_r && !ref_pend_r;
   // Event in the clear cycle still sets
   assign pend_nxt = (pend_r & ~(wr_icr ? wr_data_i[`IRQ_W-1:0] : '0)) | ev;

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         busy_d_r <= 1'b0;
         ref_pend_d_r <= 1'b0;
         pend_r <= '0;
      end else begin
         busy_d_r <= m.busy;
         ref_pend_d_r <= ref_pend_r;
         pend_r <= pend_nxt;
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(pend_r & mask_r);
      end
   end

   always_comb begin
      rd_val = '0;
      if (hit(addr_i, `OFF_MODE)) begin
         rd_val = mode_r;
      end else if (hit(addr_i, `OFF_STATUS)) begin
         rd_val[`STAT_BUSY_BIT] = m.busy;
         rd_val[`STAT_RPEND_BIT] = ref_pend_r;
      end else if (hit(addr_i, `OFF_VALUE)) begin
         rd_val[`VALUE_W-1:0] = m.result;
      end else if (hit(addr_i, `OFF_IMR)) begin
         rd_val[`IRQ_W-1:0] = mask_r;
      end else if (hit(addr_i, `OFF_ISR)) begin
         rd_val[`IRQ_W-1:0] = pend_r;
      end else if (hit(addr_i, `OFF_VERSION)) begin
         rd_val = {12'h000, VARIANT_NUM, 4'h0, VERSION_NUM};
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_data_r <= '0;
      end else begin
         rd_data_r <= rd_en_i ? rd_val : '0;
      end
   end

   assign rd_data_o = rd_data_r;
   assign irq_o = irq_r;

   start_busy_a : assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      (wr_ctrl && wr_data_i[`START_BIT]) |=> m.busy)
      else $error("start did not raise busy");
   start_zero_a : assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      (wr_ctrl && !wr_data_i[`START_BIT] && !m.busy) |=> !m.busy)
      else $error("zero start launched a measurement");
   status_busy_a : assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      (rd_en_i && hit(addr_i, `OFF_STATUS)) |=>
         rd_data_r[`STAT_BUSY_BIT] == $past(m.busy))
      else $error("status busy bit wrong");
   mode_pend_a : assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      wr_mode |=> ref_pend_r)
      else $error("mode write did not set pending");
   gate_off_a : assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      !ref_gate_r |-> !m.ref_edge)
      else $error("reference edge passed a closed gate");
   done_set_a : assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      $fell(m.busy) |=> pend_r[`IRQ_DONE_BIT])
      else $error("done pending not set");
   rdy_set_a : assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      $fell(ref_pend_r) |=> pend_r[`IRQ_RDY_BIT])
      else $error("ready pending not set");
   ier_set_a : assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      (wr_ier && wr_data_i[`IRQ_DONE_BIT]) |=> mask_r[`IRQ_DONE_BIT])
      else $error("enable-set ignored");
   idr_clr_a : assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      (wr_idr && wr_data_i[`IRQ_RDY_BIT]) |=> !mask_r[`IRQ_RDY_BIT])
      else $error("enable-clear ignored");
   icr_clr_a : assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      (wr_icr && wr_data_i[`IRQ_DONE_BIT] && !ev[`IRQ_DONE_BIT])
         |=> !pend_r[`IRQ_DONE_BIT])
      else $error("pending clear ignored");
   irq_on_a : assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      (|(pend_r & mask_r)) |=> irq_o)
      else $error("interrupt missing");
   irq_off_a : assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      !(|(pend_r & mask_r)) |=> !irq_o)
      else $error("spurious interrupt");
   value_rd_a : assert property (
      @(posedge clock_i) disable iff (!rstn_i)
      (rd_en_i && hit(addr_i, `OFF_VALUE)) |=>
         rd_data_o[31:`VALUE_W] == '0 && rd_data_o[`VALUE_W-1:0] == $past(m.result))
      else $error("result read wrong");
endmodule : freq_meter

`default_nettype wire

// *** dv/testbench.sv ***
// Purpose: Self-checking bench of the frequency meter register block
// Assumes: Source clocks made here, locked to clock_i, all below clock_i/2
// Notes: Flags are sampled through register reads; irq_o is sampled directly
`include "freq_meter_consts.svh"
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [`ADDR_W-1:0] addr_i = '0;
   logic [31:0] wr_data_i = '0;
   logic wr_en_i = 1'b0;
   logic rd_en_i = 1'b0;
   logic [31:0] rd_data_o;
   logic [31:0] meas_src_i = '0;
   logic [7:0] ref_src_i = '0;
   logic irq_o;
   logic [7:0] cnt = 8'h00;
   logic [31:0] prev = 32'h0000_0000;
   int errors = 0;
   int checks = 0;

   always #5 clock_i = ~clock_i;

   // Measured 0/1: 4/8 cycles, others 16; reference 0/1: 64/32 cycles, others 128
   always_ff @(posedge clock_i) begin
      cnt <= cnt + 8'h01;
      meas_src_i <= {{30{cnt[3]}}, cnt[2], cnt[1]};
      ref_src_i <= {{6{cnt[6]}}, cnt[4], cnt[5]};
   end

   // Identification values are arbitrary
   freq_meter #(.VERSION_NUM(12'h5A6), .VARIANT_NUM(4'h3)) dut (
      .clock_i(clock_i),
      .rstn_i(rstn_i),
      .addr_i(addr_i),
      .wr_data_i(wr_data_i),
      .wr_en_i(wr_en_i),
      .rd_en_i(rd_en_i),
      .rd_data_o(rd_data_o),
      .meas_src_i(meas_src_i),
      .ref_src_i(ref_src_i),
      .irq_o(irq_o)
   );

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results

   task automatic wr(input logic [`ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_en_i <= 1'b1;
      @(posedge clock_i);
      wr_en_i <= 1'b0;
   endtask : wr

   task automatic rd(input logic [`ADDR_W-1:0] a, output logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      rd_en_i <= 1'b1;
      @(posedge clock_i);
      rd_en_i <= 1'b0;
      @(negedge clock_i);
      d = rd_data_o;
   endtask : rd

   task automatic rd_chk(input logic [`ADDR_W-1:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      check(d, exp);
   endtask : rd_chk

   // Poll one status bit, bounded
   task automatic wait_status(input int b, input logic v, input int bound);
      logic [31:0] s;
      int i;
      for (i = 0; i < bound; i++) begin
         rd(`OFF_STATUS, s);
         if (s[b] === v) begin
            break;
         end
      end
      if (i == bound) begin
         errors++;
         $display("FAIL at %0t: status wait ran out, seen %h", $time, s);
         results();
      end
   endtask : wait_status

   task automatic test_reset();
      logic [`ADDR_W-1:0] a [11];
      logic [31:0] e [11];
      a = '{`OFF_CTRL, `OFF_MODE, `OFF_STATUS, `OFF_VALUE, `OFF_IER, `OFF_IDR,
            `OFF_IMR, `OFF_ISR, `OFF_ICR, `OFF_VERSION, 10'h100};
      e = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
            32'h0003_05A6, 32'h0};
      check({31'h0, irq_o}, 32'h0);
      wr(`OFF_VERSION, 32'hFFFF_FFFF);
      wr(`OFF_VALUE, 32'hFFFF_FFFF);
      for (int i = 0; i < 11; i++) begin
         rd_chk(a[i], e[i]);
      end
      @(negedge clock_i);
      check(rd_data_o, 32'h0);
      $display("Test reset done");
   endtask : test_reset

   task automatic test_mode();
      for (int i = 0; i < 200 && cnt[6:0] !== 7'h48; i++) begin
         @(negedge clock_i);
      end
      wr(`OFF_MODE, 32'hFFFF_FFFF);
      rd_chk(`OFF_STATUS, 32'h0000_0002);
      rd_chk(`OFF_MODE, 32'h801F_FF07);
      wait_status(1, 1'b0, 200);
      rd_chk(`OFF_ISR, 32'h0000_0002);
      wr(`OFF_ICR, 32'h0000_0002);
      $display("Test mode done");
   endtask : test_mode

   task automatic test_measure();
      logic [31:0] m [4];
      logic [31:0] e [4];
      m = '{32'h8000_0400, 32'h8001_0400, 32'h8000_0201, 32'h8000_0001};
      e = '{32'h0000_0040, 32'h0000_0020, 32'h0000_0010, 32'h0000_0800};
      for (int i = 0; i < 4; i++) begin
         wr(`OFF_MODE, m[i]);
         wait_status(1, 1'b0, 100);
         wr(`OFF_ICR, 32'h0000_0003);
         wr(`OFF_CTRL, 32'hFFFF_FFFE);
         rd_chk(`OFF_STATUS, 32'h0000_0000);
         wr(`OFF_CTRL, 32'h0000_0001);
         rd_chk(`OFF_STATUS, 32'h0000_0001);
         rd_chk(`OFF_VALUE, prev);
         wait_status(0, 1'b0, 10000);
         rd_chk(`OFF_VALUE, e[i]);
         rd_chk(`OFF_ISR, 32'h0000_0001);
         prev = e[i];
      end
      $display("Test measure done");
   endtask : test_measure

   task automatic test_irq();
      check({31'h0, irq_o}, 32'h0);
      wr(`OFF_IER, 32'h0000_0000);
      rd_chk(`OFF_IMR, 32'h0000_0000);
      wr(`OFF_IER, 32'h0000_0001);
      rd_chk(`OFF_IMR, 32'h0000_0001);
      check({31'h0, irq_o}, 32'h1);
      wr(`OFF_IER, 32'h0000_0002);
      wr(`OFF_IDR, 32'h0000_0000);
      rd_chk(`OFF_IMR, 32'h0000_0003);
      wr(`OFF_IDR, 32'h0000_0001);
      rd_chk(`OFF_IMR, 32'h0000_0002);
      check({31'h0, irq_o}, 32'h0);
      wr(`OFF_ICR, 32'h0000_0000);
      rd_chk(`OFF_ISR, 32'h0000_0001);
      wr(`OFF_ICR, 32'h0000_0001);
      rd_chk(`OFF_ISR, 32'h0000_0000);
      wr(`OFF_MODE, 32'h0000_0000);
      wait_status(1, 1'b0, 100);
      rd_chk(`OFF_ISR, 32'h0000_0002);
      check({31'h0, irq_o}, 32'h1);
      wr(`OFF_ICR, 32'h0000_0002);
      rd_chk(`OFF_ISR, 32'h0000_0000);
      check({31'h0, irq_o}, 32'h0);
      $display("Test interrupt done");
   endtask : test_irq

   initial begin
      repeat (3) @(posedge clock_i);
      rstn_i <= 1'b1;
      @(posedge clock_i);
      test_reset();
      test_mode();
      test_measure();
      test_irq();
      results();
   end
endmodule : testbench

`default_nettype wire
